// ==== tucfg_top.sv ====
/*
 * Texture unit configuration registers and the small datapaths they steer:
 * endian swap of texture words, detail factor, filter selection, base
 * address selection, stall levels, resets and configuration read-back.
 * Assumes an APB master on CLK_I and inputs synchronous to CLK_I.
 */
`timescale 1ns/1ns
`default_nettype none

module tucfg_top (
    input  wire logic                      CLK_I,
    input  wire logic                      RST_I,
    input  wire logic                      PSEL_I,
    input  wire logic                      PENABLE_I,
    input  wire logic                      PWRITE_I,
    input  wire logic [7:0]                PADDR_I,
    input  wire logic [31:0]               PWDATA_I,
    output logic      [31:0]               PRDATA_O,
    output logic                           PREADY_O,
    output logic                           PSLVERR_O,
    input  wire logic [31:0]               TEX_WORD_I,
    input  wire logic                      TEX_VALID_I,
    output logic      [31:0]               TEX_MEM_WORD_O,
    output logic                           TEX_MEM_VALID_O,
    output logic      [19:0]               DOWNLOAD_BASE_O,
    input  wire logic [3:0]                LEVEL_BASE_INDEX_I,
    output logic      [19:0]               RENDER_BASE_O,
    output logic                           TILED_O,
    output logic      [6:0]                TILE_STRIDE_O,
    input  wire logic [5:0]                DETAIL_LOD_I,
    output logic      [7:0]                DETAIL_FACTOR_O,
    input  wire logic                      MODE_MIN_FILTER_I,
    input  wire logic                      MODE_MAG_FILTER_I,
    output tucfg_pkg::tucfg_filter_type    FILTER_SEL_O,
    input  wire logic [4:0]                PIXEL_FIFO_FREE_I,
    input  wire logic [3:0]                UPSTREAM_FIFO_FREE_I,
    output logic                           PIXEL_STALL_O,
    output logic                           UPSTREAM_STALL_O,
    output logic      [3:0]                TRANSMIT_CLOCK_PHASE_ADJ_O,
    input  wire logic                      CLOCK_SENSE_I,
    output logic                           UPSTREAM_EXPECTED_O,
    output logic                           QUEUE_RESET_O,
    output logic                           GRAPHICS_RESET_O,
    output tucfg_pkg::tucfg_debug_type     DEBUG_OPTS_O,
    input  wire tucfg_pkg::tucfg_argb_type TEXEL_I,
    input  wire logic                      TEXEL_VALID_I,
    output tucfg_pkg::tucfg_argb_type      OUTPUT_BUS_WORD_O,
    output logic                           OUTPUT_BUS_VALID_O
);

    typedef struct packed {
        logic [31:0]                  lod_ctrl;
        logic [31:0]                  detail;
        logic [31:0]                  base;
        logic [31:0]                  base_l1;
        logic [31:0]                  base_l2;
        logic [31:0]                  base_l38;
        logic [31:0]                  init;
        logic [31:0]                  prdata;
        logic                         pready;
        logic                         pslverr;
        logic [31:0]                  tex_word;
        logic                         tex_valid;
        logic [19:0]                  render_base;
        logic                         tiled;
        logic [6:0]                   stride;
        logic [7:0]                   detail_factor;
        tucfg_pkg::tucfg_filter_type  filter;
        logic                         pixel_stall;
        logic                         upstream_stall;
        logic                         upstream_expected;
        tucfg_pkg::tucfg_argb_type    out_word;
        logic                         out_valid;
    } tucfg_state_type;

    tucfg_state_type state_reg;
    tucfg_state_type state_next;

    // Endian swap of one texture word
    function automatic logic [31:0] endian_fix(input logic [31:0] w,
                                               input logic        rev,
                                               input logic        swap);
        logic [31:0] b;
        b = rev ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
        return swap ? {b[15:0], b[31:16]} : b;
    endfunction : endian_fix

    // Blend factor from detail fields and level of detail
    function automatic logic [7:0] detail_calc(input logic [31:0] d,
                                               input logic [5:0]  lod);
        logic signed [7:0]  diff;
        logic signed [15:0] shifted;
        logic [7:0]         sat;
        logic [7:0]         limit;
        limit   = d[tucfg_pkg::DET_LIMIT_LSB +: 8];
        diff    = 8'(signed'(d[tucfg_pkg::DET_BIAS_LSB +: 6])) - 8'({2'h0, lod});
        shifted = 16'(diff) <<< d[tucfg_pkg::DET_SCALE_LSB +: 3];
        if (shifted < 0) begin
            sat = 8'h00;
        end else if (shifted > 16'sh00ff) begin
            sat = 8'hff;
        end else begin
            sat = shifted[7:0];
        end
        return (sat > limit) ? sat : limit;
    endfunction : detail_calc

    // Register read decode, reserved bits masked
    function automatic logic [32:0] read_word(input logic [7:0]      a,
                                              input tucfg_state_type s);
        unique case (a)
            tucfg_pkg::OFS_LOD_CTRL: return {1'b1, s.lod_ctrl};
            tucfg_pkg::OFS_DETAIL:   return {1'b1, s.detail};
            tucfg_pkg::OFS_BASE:     return {1'b1, s.base & tucfg_pkg::MASK_BASE};
            tucfg_pkg::OFS_BASE_L1:  return {1'b1, s.base_l1};
            tucfg_pkg::OFS_BASE_L2:  return {1'b1, s.base_l2};
            tucfg_pkg::OFS_BASE_L38: return {1'b1, s.base_l38};
            tucfg_pkg::OFS_INIT:     return {1'b1, s.init};
            tucfg_pkg::OFS_STATUS:   return {1'b1, 29'h0, s.upstream_expected,
                                             s.upstream_stall, s.pixel_stall};
            default:                 return {1'b0, 32'h0};
        endcase
    endfunction : read_word

    logic        access;
    logic        wr_done;
    logic [32:0] rd;
    logic        multi;
    logic        separate;

    always_comb begin
        state_next = state_reg;
        access     = PSEL_I & PENABLE_I;
        wr_done    = access & state_reg.pready & PWRITE_I;
        rd         = read_word(PADDR_I, state_reg);
        multi      = state_reg.lod_ctrl[tucfg_pkg::LOD_MULTI_BASE_BIT];
        separate   = state_reg.detail[tucfg_pkg::DET_SEPARATE_BIT];

        // APB: one wait state, answer on second access cycle
        state_next.pready  = access & ~state_reg.pready;
        state_next.pslverr = access & ~state_reg.pready & ~rd[32];
        state_next.prdata  = (access & ~state_reg.pready & ~PWRITE_I) ? rd[31:0] : 32'h0;

        if (wr_done) begin
            unique case (PADDR_I)
                tucfg_pkg::OFS_LOD_CTRL:
                    state_next.lod_ctrl = PWDATA_I & tucfg_pkg::MASK_LOD_CTRL;
                tucfg_pkg::OFS_DETAIL:
                    state_next.detail   = PWDATA_I & tucfg_pkg::MASK_DETAIL;
                tucfg_pkg::OFS_BASE:
                    state_next.base     = PWDATA_I;
                tucfg_pkg::OFS_BASE_L1:
                    state_next.base_l1  = PWDATA_I & tucfg_pkg::MASK_BASE_LVL;
                tucfg_pkg::OFS_BASE_L2:
                    state_next.base_l2  = PWDATA_I & tucfg_pkg::MASK_BASE_LVL;
                tucfg_pkg::OFS_BASE_L38:
                    state_next.base_l38 = PWDATA_I & tucfg_pkg::MASK_BASE_LVL;
                tucfg_pkg::OFS_INIT:
                    state_next.init     = PWDATA_I & tucfg_pkg::MASK_INIT;
                default: ;
            endcase
        end

        // Texture words pass through the endian swap, one per cycle
        state_next.tex_word  = endian_fix(TEX_WORD_I,
                                   state_reg.lod_ctrl[tucfg_pkg::LOD_BYTE_REV_BIT],
                                   state_reg.lod_ctrl[tucfg_pkg::LOD_HALF_SWAP_BIT]);
        state_next.tex_valid = TEX_VALID_I;

        // Base address by level index
        if (multi && LEVEL_BASE_INDEX_I == 4'h1) begin
            state_next.render_base = state_reg.base_l1[tucfg_pkg::BASE_ADDR_LSB +: 20];
        end else if (multi && LEVEL_BASE_INDEX_I == 4'h2) begin
            state_next.render_base = state_reg.base_l2[tucfg_pkg::BASE_ADDR_LSB +: 20];
        end else if (multi && LEVEL_BASE_INDEX_I >= 4'h3) begin
            state_next.render_base = state_reg.base_l38[tucfg_pkg::BASE_ADDR_LSB +: 20];
        end else begin
            state_next.render_base = state_reg.base[tucfg_pkg::BASE_ADDR_LSB +: 20];
        end
        state_next.tiled  = state_reg.base[tucfg_pkg::BASE_TILED_BIT];
        state_next.stride = state_reg.base[tucfg_pkg::BASE_TILED_BIT] ?
                            state_reg.base[tucfg_pkg::BASE_STRIDE_LSB +: 7] : 7'h0;

        state_next.detail_factor = detail_calc(state_reg.detail, DETAIL_LOD_I);

        // Filter choice, one means bilinear
        if (separate) begin
            state_next.filter.rgb_min_bilinear = state_reg.detail[tucfg_pkg::DET_RGB_MIN_BIT];
            state_next.filter.rgb_mag_bilinear = state_reg.detail[tucfg_pkg::DET_RGB_MAG_BIT];
            state_next.filter.a_min_bilinear   = state_reg.detail[tucfg_pkg::DET_A_MIN_BIT];
            state_next.filter.a_mag_bilinear   = state_reg.detail[tucfg_pkg::DET_A_MAG_BIT];
        end else begin
            state_next.filter = {MODE_MIN_FILTER_I, MODE_MAG_FILTER_I,
                                 MODE_MIN_FILTER_I, MODE_MAG_FILTER_I};
        end

        // Stall when free space falls to the level
        state_next.pixel_stall    = PIXEL_FIFO_FREE_I <=
                                    state_reg.init[tucfg_pkg::INIT_PIX_STALL_LSB +: 5];
        state_next.upstream_stall = UPSTREAM_FIFO_FREE_I <=
                                    state_reg.init[tucfg_pkg::INIT_UP_STALL_LSB +: 4];

        state_next.upstream_expected = state_reg.init[tucfg_pkg::INIT_OVERRIDE_BIT] ?
                                       ~state_reg.init[tucfg_pkg::INIT_UP_IGNORE_BIT] :
                                       CLOCK_SENSE_I;

        // Output bus: texels or configuration read-back
        if (state_reg.init[tucfg_pkg::INIT_SEND_CFG_BIT]) begin
            unique case (state_reg.init[tucfg_pkg::INIT_CFG_SEL_LSB +: 3])
                tucfg_pkg::CFG_SEL_INIT: state_next.out_word = state_reg.init;
                tucfg_pkg::CFG_SEL_BASE: state_next.out_word = state_reg.base;
                default:                 state_next.out_word = 32'h0;
            endcase
            state_next.out_valid = 1'b1;
        end else begin
            state_next.out_word  = TEXEL_I;
            state_next.out_valid = TEXEL_VALID_I;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg          <= '0;
            state_reg.lod_ctrl <= tucfg_pkg::RST_REG;
            state_reg.init     <= tucfg_pkg::RST_REG;
        end else begin
            state_reg <= state_next;
        end
    end

    assign PRDATA_O                   = state_reg.prdata;
    assign PREADY_O                   = state_reg.pready;
    assign PSLVERR_O                  = state_reg.pslverr;
    assign TEX_MEM_WORD_O             = state_reg.tex_word;
    assign TEX_MEM_VALID_O            = state_reg.tex_valid;
    assign DOWNLOAD_BASE_O            = state_reg.base[tucfg_pkg::BASE_ADDR_LSB +: 20];
    assign RENDER_BASE_O              = state_reg.render_base;
    assign TILED_O                    = state_reg.tiled;
    assign TILE_STRIDE_O              = state_reg.stride;
    assign DETAIL_FACTOR_O            = state_reg.detail_factor;
    assign FILTER_SEL_O               = state_reg.filter;
    assign PIXEL_STALL_O              = state_reg.pixel_stall;
    assign UPSTREAM_STALL_O           = state_reg.upstream_stall;
    assign TRANSMIT_CLOCK_PHASE_ADJ_O = state_reg.init[tucfg_pkg::INIT_PHASE_LSB +: 4];
    assign UPSTREAM_EXPECTED_O        = state_reg.upstream_expected;
    assign QUEUE_RESET_O              = state_reg.init[tucfg_pkg::INIT_QUEUE_RST_BIT];
    assign GRAPHICS_RESET_O           = state_reg.init[tucfg_pkg::INIT_GFX_RST_BIT];
    assign DEBUG_OPTS_O               = state_reg.init[tucfg_pkg::INIT_DEBUG_LSB +: 5];
    assign OUTPUT_BUS_WORD_O          = state_reg.out_word;
    assign OUTPUT_BUS_VALID_O         = state_reg.out_valid;

    a_byte_reverse: assert property (@(posedge CLK_I) disable iff (RST_I)
        state_reg.lod_ctrl[25] && !state_reg.lod_ctrl[26]
        |=> TEX_MEM_WORD_O == {$past(TEX_WORD_I[7:0]), $past(TEX_WORD_I[15:8]),
                               $past(TEX_WORD_I[23:16]), $past(TEX_WORD_I[31:24])})
        else $error("byte reversal wrong");

    a_half_swap: assert property (@(posedge CLK_I) disable iff (RST_I)
        state_reg.lod_ctrl[25] && state_reg.lod_ctrl[26]
        |=> TEX_MEM_WORD_O == {$past(TEX_WORD_I[23:16]), $past(TEX_WORD_I[31:24]),
                               $past(TEX_WORD_I[7:0]), $past(TEX_WORD_I[15:8])})
        else $error("swap order wrong");

    a_detail_floor: assert property (@(posedge CLK_I) disable iff (RST_I)
        1'b1 |=> DETAIL_FACTOR_O >= $past(state_reg.detail[7:0]))
        else $error("detail factor below limit");

    a_filter_shared: assert property (@(posedge CLK_I) disable iff (RST_I)
        !state_reg.detail[21] |=> FILTER_SEL_O.a_mag_bilinear == $past(MODE_MAG_FILTER_I)
                               && FILTER_SEL_O.rgb_min_bilinear == $past(MODE_MIN_FILTER_I))
        else $error("shared filter wrong");

    a_level_two: assert property (@(posedge CLK_I) disable iff (RST_I)
        state_reg.lod_ctrl[24] && LEVEL_BASE_INDEX_I == 4'h2
        |=> RENDER_BASE_O == $past(state_reg.base_l2[23:4]))
        else $error("level two base wrong");

    a_level_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
        LEVEL_BASE_INDEX_I == 4'h0 |=> RENDER_BASE_O == DOWNLOAD_BASE_O || $changed(DOWNLOAD_BASE_O))
        else $error("primary base not used");

    a_pixel_stall: assert property (@(posedge CLK_I) disable iff (RST_I)
        PIXEL_FIFO_FREE_I > state_reg.init[6:2] ##1 $stable(state_reg.init) |-> !PIXEL_STALL_O)
        else $error("stall above level");

    a_upstream_sel: assert property (@(posedge CLK_I) disable iff (RST_I)
        !state_reg.init[17] |=> UPSTREAM_EXPECTED_O == $past(CLOCK_SENSE_I))
        else $error("clock sense not followed");

    a_config_base: assert property (@(posedge CLK_I) disable iff (RST_I)
        state_reg.init[18] && state_reg.init[25:23] == 3'h4
        |=> OUTPUT_BUS_WORD_O == $past(state_reg.base) && OUTPUT_BUS_VALID_O)
        else $error("base read-back wrong");

    a_apb_wait: assert property (@(posedge CLK_I) disable iff (RST_I)
        PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O ##1 !PREADY_O)
        else $error("ready timing wrong");

endmodule : tucfg_top

`default_nettype wire

// ==== tucfg_pkg.sv ====
/*
 * Package for the texture unit configuration block: register offsets,
 * field positions, reset values and the carrier structs.
 * Assumes a 32-bit APB bus with byte addresses and one core clock.
 */
`default_nettype none
package tucfg_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_LOD_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DETAIL     = 8'h04;
    localparam logic [7:0] OFS_BASE       = 8'h08;
    localparam logic [7:0] OFS_BASE_L1    = 8'h0c;
    localparam logic [7:0] OFS_BASE_L2    = 8'h10;
    localparam logic [7:0] OFS_BASE_L38   = 8'h14;
    localparam logic [7:0] OFS_INIT       = 8'h18;
    localparam logic [7:0] OFS_STATUS     = 8'h1c;

    // Level-of-detail control fields
    localparam int LOD_MULTI_BASE_BIT     = 24;
    localparam int LOD_BYTE_REV_BIT       = 25;
    localparam int LOD_HALF_SWAP_BIT      = 26;

    // Detail control fields
    localparam int DET_LIMIT_LSB          = 0;
    localparam int DET_BIAS_LSB           = 8;
    localparam int DET_SCALE_LSB          = 14;
    localparam int DET_RGB_MIN_BIT        = 17;
    localparam int DET_RGB_MAG_BIT        = 18;
    localparam int DET_A_MIN_BIT          = 19;
    localparam int DET_A_MAG_BIT          = 20;
    localparam int DET_SEPARATE_BIT       = 21;

    // Base address fields
    localparam int BASE_TILED_BIT         = 0;
    localparam int BASE_ADDR_LSB          = 4;
    localparam int BASE_STRIDE_LSB        = 25;

    // Initialisation fields
    localparam int INIT_PIX_STALL_LSB     = 2;
    localparam int INIT_UP_STALL_LSB      = 7;
    localparam int INIT_PHASE_LSB         = 12;
    localparam int INIT_UP_IGNORE_BIT     = 16;
    localparam int INIT_OVERRIDE_BIT      = 17;
    localparam int INIT_SEND_CFG_BIT      = 18;
    localparam int INIT_QUEUE_RST_BIT     = 19;
    localparam int INIT_GFX_RST_BIT       = 20;
    localparam int INIT_CFG_SEL_LSB       = 23;
    localparam int INIT_DEBUG_LSB         = 26;

    // Writable bit masks, MASK_BASE applied on read only; everything else reads zero
    localparam logic [31:0] MASK_LOD_CTRL = 32'h0700_0000;
    localparam logic [31:0] MASK_DETAIL   = 32'h003f_ffff;
    localparam logic [31:0] MASK_BASE     = 32'hfeff_fff1;
    localparam logic [31:0] MASK_BASE_LVL = 32'h00ff_fff0;
    localparam logic [31:0] MASK_INIT     = 32'h7f9f_f7fc;

    // Reset values
    localparam logic [31:0] RST_REG       = 32'h0000_0000;

    // Configuration transmit selects
    localparam logic [2:0]  CFG_SEL_INIT  = 3'h3;
    localparam logic [2:0]  CFG_SEL_BASE  = 3'h4;

    typedef struct packed {
        logic [7:0] alpha;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } tucfg_argb_type;

    typedef struct packed {
        logic       force_quad_fetch;
        logic       cache_inv_per_tri;
        logic       nop_per_tri;
        logic       attr_set_a_only;
        logic       short_coord_fraction;
    } tucfg_debug_type;

    typedef struct packed {
        logic       rgb_min_bilinear;
        logic       rgb_mag_bilinear;
        logic       a_min_bilinear;
        logic       a_mag_bilinear;
    } tucfg_filter_type;

endpackage : tucfg_pkg
`default_nettype wire

// ==== tucfg_pixel_sink.sv ====
/*
 * Pixel unit stand-in: keeps the last word seen on the output bus.
 * Assumes the bus and its valid are registered on clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module tucfg_pixel_sink (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire tucfg_pkg::tucfg_argb_type word_i,
    input  wire logic                      valid_i,
    output logic      [31:0]               last_o,
    output logic      [15:0]               count_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_o  <= 32'h0;
            count_o <= 16'h0;
        end else if (valid_i) begin
            last_o  <= {word_i.alpha, word_i.red, word_i.green, word_i.blue};
            count_o <= count_o + 16'h1;
        end
    end
endmodule : tucfg_pixel_sink
`default_nettype wire

// ==== test_texture_unit_config_regs.sv ====
/*
 * Random bench for the texture unit configuration block.
 * Assumes tucfg_pkg, tucfg_top and tucfg_pixel_sink compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module test_texture_unit_config_regs;
    logic        CLK_I = 1'b0, RST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
    logic        TEX_VALID_I = 1'b0, MODE_MIN_FILTER_I = 1'b0, MODE_MAG_FILTER_I = 1'b0;
    logic        CLOCK_SENSE_I = 1'b0, TEXEL_VALID_I = 1'b0, PREADY_O, PSLVERR_O, TILED_O;
    logic        TEX_MEM_VALID_O, PIXEL_STALL_O, UPSTREAM_STALL_O, UPSTREAM_EXPECTED_O;
    logic        QUEUE_RESET_O, GRAPHICS_RESET_O, OUTPUT_BUS_VALID_O, sl;
    logic [3:0]  LEVEL_BASE_INDEX_I = 4'h0, UPSTREAM_FIFO_FREE_I = 4'hf, TRANSMIT_CLOCK_PHASE_ADJ_O;
    logic [4:0]  PIXEL_FIFO_FREE_I = 5'h1f;
    logic [5:0]  DETAIL_LOD_I = 6'h0;
    logic [6:0]  TILE_STRIDE_O;
    logic [7:0]  PADDR_I = 8'h0, DETAIL_FACTOR_O;
    logic [15:0] word_count;
    logic [19:0] DOWNLOAD_BASE_O, RENDER_BASE_O;
    logic [31:0] PWDATA_I = 32'h0, TEX_WORD_I = 32'h0, PRDATA_O, TEX_MEM_WORD_O, rd, v, base;
    logic [31:0] l1, l2, l38, last_word, seed = 32'h23ff;
    tucfg_pkg::tucfg_filter_type FILTER_SEL_O;
    tucfg_pkg::tucfg_debug_type  DEBUG_OPTS_O;
    tucfg_pkg::tucfg_argb_type   TEXEL_I = 32'h0, OUTPUT_BUS_WORD_O;
    logic [31:0] masks [7] = '{tucfg_pkg::MASK_LOD_CTRL, tucfg_pkg::MASK_DETAIL,
        tucfg_pkg::MASK_BASE, tucfg_pkg::MASK_BASE_LVL, tucfg_pkg::MASK_BASE_LVL,
        tucfg_pkg::MASK_BASE_LVL, tucfg_pkg::MASK_INIT};
    int          err_count = 0, total_checks = 0;

    always #10 CLK_I = ~CLK_I;

    tucfg_top uut (.CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
        .PRDATA_O, .PREADY_O, .PSLVERR_O, .TEX_WORD_I, .TEX_VALID_I, .TEX_MEM_WORD_O,
        .TEX_MEM_VALID_O, .DOWNLOAD_BASE_O, .LEVEL_BASE_INDEX_I, .RENDER_BASE_O, .TILED_O,
        .TILE_STRIDE_O, .DETAIL_LOD_I, .DETAIL_FACTOR_O, .MODE_MIN_FILTER_I, .MODE_MAG_FILTER_I,
        .FILTER_SEL_O, .PIXEL_FIFO_FREE_I, .UPSTREAM_FIFO_FREE_I, .PIXEL_STALL_O,
        .UPSTREAM_STALL_O, .TRANSMIT_CLOCK_PHASE_ADJ_O, .CLOCK_SENSE_I, .UPSTREAM_EXPECTED_O,
        .QUEUE_RESET_O, .GRAPHICS_RESET_O, .DEBUG_OPTS_O, .TEXEL_I, .TEXEL_VALID_I,
        .OUTPUT_BUS_WORD_O, .OUTPUT_BUS_VALID_O);
    tucfg_pixel_sink peer (.clk_i(CLK_I), .rst_i(RST_I), .word_i(OUTPUT_BUS_WORD_O),
        .valid_i(OUTPUT_BUS_VALID_O), .last_o(last_word), .count_o(word_count));

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] swp(logic [31:0] w, logic r, logic h);
        if (r) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
        if (h) w = {w[15:0], w[31:16]};
        return w;
    endfunction : swp
    function automatic logic [7:0] dfac(logic [31:0] r, logic [5:0] lod);
        int d;
        d = int'($signed(r[13:8])) - int'(lod);
        if (d < 0) d = 0;
        d = d << r[16:14];
        if (d > 255) d = 255;
        return (r[7:0] > d) ? r[7:0] : d[7:0];
    endfunction : dfac
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge CLK_I);
    endtask : tick
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK_I);
        {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} <= {2'b10, w, a, d};
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        n = 0;
        do @(posedge CLK_I); while (PREADY_O !== 1'b1 && ++n < 20);
        chk("ready", 1'b1, PREADY_O);
        rd = PRDATA_O;
        sl = PSLVERR_O;
        {PSEL_I, PENABLE_I} <= 2'b00;
    endtask : apb
    task complete_run();
        $display("Checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        #400000;
        err_count++;
        complete_run();
    end

    initial begin
        tick(2);
        RST_I <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            chk("reset value", 32'h0, rd);
            v = rnd();
            apb(1'b1, 8'(4 * k), v);
            apb(1'b0, 8'(4 * k), 32'h0);
            chk("read back", v & masks[k], rd);
            chk("no error", 1'b0, sl);
        end
        apb(1'b1, 8'h20, v);
        chk("slave error", 1'b1, sl);
        apb(1'b1, tucfg_pkg::OFS_INIT, 32'h0);
        $display("Test registers done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, tucfg_pkg::OFS_LOD_CTRL, {5'h0, k[1:0], 25'h0});
            v = rnd();
            @(posedge CLK_I);
            {TEX_WORD_I, TEX_VALID_I} <= {v, 1'b1};
            tick(2);
            chk("texture word", swp(v, k[0], k[1]), TEX_MEM_WORD_O);
            chk("texture valid", 1'b1, TEX_MEM_VALID_O);
        end
        $display("Test swap done");
        l1 = rnd();
        l2 = rnd();
        l38 = rnd();
        apb(1'b1, tucfg_pkg::OFS_BASE_L1, l1);
        apb(1'b1, tucfg_pkg::OFS_BASE_L2, l2);
        apb(1'b1, tucfg_pkg::OFS_BASE_L38, l38);
        for (int m = 0; m < 4; m++) begin
            v = rnd();
            base = {v[31:1], m[1]};
            apb(1'b1, tucfg_pkg::OFS_BASE, base);
            apb(1'b1, tucfg_pkg::OFS_LOD_CTRL, {7'h0, m[0], 24'h0});
            for (int i = 0; i < 16; i++) begin
                @(posedge CLK_I);
                LEVEL_BASE_INDEX_I <= i[3:0];
                tick(3);
                chk("render base", (m[0] == 1'b0 || i == 0) ? base[23:4] : i == 1 ? l1[23:4] :
                    i == 2 ? l2[23:4] : l38[23:4], RENDER_BASE_O);
            end
            chk("download base", base[23:4], DOWNLOAD_BASE_O);
            chk("tiled", base[0], TILED_O);
            chk("stride", base[0] ? base[31:25] : 7'h0, TILE_STRIDE_O);
        end
        $display("Test base done");
        for (int k = 0; k < 24; k++) begin
            v = rnd();
            if (k < 2) v = k ? 32'h0001_df00 : 32'h0000_1f00;
            apb(1'b1, tucfg_pkg::OFS_DETAIL, v);
            @(posedge CLK_I);
            {DETAIL_LOD_I, MODE_MIN_FILTER_I, MODE_MAG_FILTER_I} <= k < 2 ? 8'h0 : seed[7:0];
            tick(3);
            chk("detail factor", dfac(v, DETAIL_LOD_I), DETAIL_FACTOR_O);
            chk("filter", v[21] ? {v[17], v[18], v[19], v[20]} :
                {2{MODE_MIN_FILTER_I, MODE_MAG_FILTER_I}}, FILTER_SEL_O);
        end
        $display("Test detail done");
        for (int k = 0; k < 16; k++) begin
            v = rnd();
            v[20:18] = 3'h0;
            apb(1'b1, tucfg_pkg::OFS_INIT, v);
            @(posedge CLK_I);
            {PIXEL_FIFO_FREE_I, UPSTREAM_FIFO_FREE_I, CLOCK_SENSE_I} <= seed[9:0];
            tick(3);
            chk("pixel stall", PIXEL_FIFO_FREE_I <= v[6:2], PIXEL_STALL_O);
            chk("upstream stall", UPSTREAM_FIFO_FREE_I <= v[10:7], UPSTREAM_STALL_O);
            chk("phase", v[15:12], TRANSMIT_CLOCK_PHASE_ADJ_O);
            chk("expect up", v[17] ? !v[16] : CLOCK_SENSE_I, UPSTREAM_EXPECTED_O);
            chk("debug", v[30:26], DEBUG_OPTS_O);
            apb(1'b0, tucfg_pkg::OFS_STATUS, 32'h0);
            chk("status", {(v[17] ? !v[16] : CLOCK_SENSE_I), (UPSTREAM_FIFO_FREE_I <= v[10:7]),
                (PIXEL_FIFO_FREE_I <= v[6:2])}, rd);
        end
        for (int k = 3; k >= 0; k--) begin
            apb(1'b1, tucfg_pkg::OFS_INIT, {11'h0, k[1:0], 19'h0});
            tick(2);
            chk("queue reset", k[0], QUEUE_RESET_O);
            chk("graphics reset", k[1], GRAPHICS_RESET_O);
        end
        $display("Test init done");
        for (int k = 0; k < 8; k++) begin
            v = rnd();
            v[25:18] = {k[2:0], 5'h01};
            apb(1'b1, tucfg_pkg::OFS_INIT, v);
            tick(4);
            chk("config word", k == 3 ? v & tucfg_pkg::MASK_INIT : k == 4 ? base : 32'h0,
                last_word);
            chk("bus valid", 1'b1, OUTPUT_BUS_VALID_O);
        end
        apb(1'b1, tucfg_pkg::OFS_INIT, 32'h0);
        @(posedge CLK_I);
        {TEXEL_I, TEXEL_VALID_I} <= {rnd(), 1'b1};
        tick(3);
        chk("texel word", TEXEL_I, last_word);
        chk("sink words", 1'b1, word_count != 16'h0);
        $display("Test send done");
        complete_run();
    end
endmodule : test_texture_unit_config_regs
`default_nettype wire
